// ==== core/capacity_pkg.sv ====
package capacity_pkg;
  // parameter store addresses for the host port
  localparam logic [7:0] ADDR_SENSE_COND  = 8'h69;
  localparam logic [7:0] ADDR_FULL_CELL_STACK_POTENTIAL   = 8'h64;
  localparam logic [7:0] ADDR_FULL_CURR   = 8'h65;
  localparam logic [7:0] ADDR_EMPTY_CELL_STACK_POTENTIAL  = 8'h66;
  localparam logic [7:0] ADDR_EMPTY_CURR  = 8'h67;
  localparam logic [7:0] ADDR_AGING_HI    = 8'h62;
  localparam logic [7:0] ADDR_AGING_LO    = 8'h63;
  localparam logic [7:0] ADDR_AGE_SCALAR  = 8'h14;
  localparam logic [7:0] ADDR_BP_LOW      = 8'h7C;
  localparam logic [7:0] ADDR_BP_MID      = 8'h7D;
  localparam logic [7:0] ADDR_BP_HIGH     = 8'h7E;
  localparam logic [7:0] ADDR_FULL40_HI   = 8'h6A;
  localparam logic [7:0] ADDR_FULL40_LO   = 8'h6B;
  localparam logic [7:0] ADDR_AE40        = 8'h6C;
  localparam logic [7:0] ADDR_SLOPE_BASE  = 8'h70;
  localparam logic [7:0] ADDR_STATUS      = 8'h01;
  localparam logic [7:0] ADDR_COUNT_HI    = 8'h10;
  localparam logic [7:0] ADDR_COUNT_LO    = 8'h11;
  // status field positions
  localparam int BIT_FULL  = 7;
  localparam int BIT_EMPTY = 6;
  localparam int BIT_LEARN = 4;
  // reset values and the age floor
  localparam logic [7:0] AGE_UNAGED   = 8'h80;
  localparam logic [7:0] AGE_MIN      = 8'h3F;
  localparam logic [7:0] BP_TOP_TEMP  = 8'h28;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;
  // aging counter multiplier
  localparam int AGING_MULT = 32;
  // slope index: curve*4 + segment
  localparam int CURVE_FULL = 0;
  localparam int CURVE_AE   = 1;
  localparam int CURVE_SE   = 2;
endpackage : capacity_pkg

// ==== core/capacity_estimator.sv ====
`timescale 1ns/100ps
`default_nettype none
module battery_capacity_estimator
  import capacity_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // parameter store port
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // nonvolatile recall and save of the age scalar
  input  wire logic        nv_recall,
  input  wire logic [7:0]  nv_age_value,
  input  wire logic        nv_save_tick,
  output logic             nv_save_req,
  output logic      [7:0]  nv_save_data,
  // measurement update
  input  wire logic        meas_update,
  input  wire logic [7:0]  cell_stack_potential,
  input  wire logic signed [15:0] sense_current,
  input  wire logic        avg_update,
  input  wire logic signed [15:0] averaged_current,
  input  wire logic signed [7:0]  temperature,
  input  wire logic [15:0] count_step,
  // coulomb count and flags
  output logic      [15:0] coulomb_count,
  output logic             full_charge_flag,
  output logic             empty_point_flag,
  output logic             learn_cycle_flag
);

  default clocking chk_cb @(posedge core_clk); // clock of all checks
  endclocking
  default disable iff (!nrst);                 // checks idle in reset

  // parameter store
  logic [7:0]  sense_conductance_reg;
  logic [7:0]  full_voltage_threshold_reg;
  logic [7:0]  full_current_threshold_reg;
  logic [7:0]  empty_voltage_threshold_reg;
  logic [7:0]  empty_current_threshold_reg;
  logic [15:0] aging_rated_charge_reg;
  logic [7:0]  age_scalar_reg;
  logic signed [7:0] bp_reg [3];           // low, mid, high breakpoints
  logic [15:0] full40_reg;                 // full at +40C
  logic [7:0]  ae40_reg;                   // empty fraction at +40C
  logic [7:0]  slope_reg [12];             // three curves, four slopes
  // detection state
  logic        cell_stack_potential_high_reg;              // voltage stayed high
  logic        avg_prev_ok_reg;            // last average qualified
  logic [1:0]  heavy_hist_reg;             // last two readings heavy
  logic        cell_stack_potential_above_reg;             // previous voltage above
  logic [20:0] aging_cnt_reg;              // discharge accumulation
  logic [15:0] empty_mark_reg;             // count at empty point
  logic [3:0]  save_div_reg;

  // curve value relative to full at +40C, 2^-14 units
  function automatic logic [15:0] curve_drop(input int c,
                                             input logic signed [7:0] t);
    int drop;
    int seg_lo;
    int seg_hi;
    int k;
    drop = 0;
    // walk each segment from +40C downward; flat above
    for (k = 3; k >= 0; k--) begin
      seg_hi = (k == 3) ? 40 : int'(bp_reg[k]);
      seg_lo = (k == 0) ? -128 : int'(bp_reg[k-1]);
      if (int'(t) < seg_hi) begin
        // slope lsb is 61ppm, one 2^-14 step per degree
        drop = drop + int'(slope_reg[c*4+k]) *
               (seg_hi - ((int'(t) > seg_lo) ? int'(t) : seg_lo));
      end
    end
    curve_drop = drop[15:0];
  endfunction : curve_drop

  // scale a 2^-14 fraction by the +40C full value
  function automatic logic [15:0] frac_of(input logic [15:0] f);
    logic [31:0] p;
    p = 32'(f) * 32'(full40_reg);
    frac_of = p[29:14];
  endfunction : frac_of

  // looked-up model points, normalized to +40C full
  logic [15:0] full_frac;
  logic [15:0] ae_frac;
  logic [15:0] full_model;
  logic [15:0] ae_model;
  logic [23:0] full_scaled;
  always_comb begin
    full_frac = 16'h4000 - curve_drop(CURVE_FULL, temperature);
    ae_frac   = ({8'h00, ae40_reg} << 6) - curve_drop(CURVE_AE,
                                                      temperature);
    if (ae_frac[15]) begin
      ae_frac = 16'h0000;
    end
    full_model  = frac_of(full_frac);
    ae_model    = frac_of(ae_frac);
    full_scaled = 24'(full_model) * 24'(age_scalar_reg);
  end

  // detection terms per update
  logic v_above_chg;
  logic v_below_ae;
  logic avg_ok;
  logic heavy_now;
  logic full_event;
  logic empty_event;
  always_comb begin
    v_above_chg = cell_stack_potential > full_voltage_threshold_reg;
    v_below_ae  = cell_stack_potential < empty_voltage_threshold_reg;
    avg_ok      = (averaged_current > 16'sh0000) &&
                  (averaged_current <
                   $signed({8'h00, full_current_threshold_reg}));
    heavy_now   = (sense_current < 16'sh0000) &&
                  ((-sense_current) >
                   $signed({8'h00, empty_current_threshold_reg}));
    full_event  = avg_update && avg_ok && avg_prev_ok_reg &&
                  cell_stack_potential_high_reg && v_above_chg;
    empty_event = meas_update && v_below_ae && cell_stack_potential_above_reg &&
                  (&heavy_hist_reg);
  end

  // continuous-voltage window between average updates
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cell_stack_potential_high_reg   <= 1'b0;
      avg_prev_ok_reg <= 1'b0;
    end else if (avg_update) begin
      cell_stack_potential_high_reg   <= v_above_chg;
      avg_prev_ok_reg <= avg_ok;
    end else if (meas_update && !v_above_chg) begin
      cell_stack_potential_high_reg   <= 1'b0; // voltage dipped in window
    end
  end

  // current history and previous voltage side
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      heavy_hist_reg <= 2'b00;
      cell_stack_potential_above_reg <= 1'b0;
    end else if (meas_update) begin
      heavy_hist_reg <= {heavy_hist_reg[0], heavy_now};
      cell_stack_potential_above_reg <= !v_below_ae;
    end
  end

  // learned age: whole coulomb count over full model, 2^-7 units
  logic [15:0] learned_charge;
  logic [31:0] learned_age;
  always_comb begin
    learned_charge = coulomb_count - empty_mark_reg;
    learned_age = (full_model == 16'h0000) ? 32'(age_scalar_reg) :
                  ((32'(learned_charge) + 32'(empty_mark_reg)) << 7) /
                  32'(full_model);
  end
  logic [7:0] age_learned_sat;
  always_comb begin
    if (learned_age > 32'(AGE_UNAGED)) begin
      age_learned_sat = AGE_UNAGED;
    end else if (learned_age < 32'(AGE_MIN)) begin
      age_learned_sat = AGE_MIN;
    end else begin
      age_learned_sat = learned_age[7:0];
    end
  end

  // aging counter reaching 32x capacity
  logic        discharging;
  logic [20:0] aging_sum;
  logic        aging_hit;
  always_comb begin
    discharging = meas_update && (sense_current < 16'sh0000);
    aging_sum   = aging_cnt_reg + 21'(count_step);
    aging_hit   = discharging &&
                  (aging_sum >= 21'(aging_rated_charge_reg) * 21'(AGING_MULT));
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      aging_cnt_reg <= '0;
    end else if (aging_hit) begin
      aging_cnt_reg <= '0;
    end else if (discharging) begin
      aging_cnt_reg <= aging_sum;
    end
  end

  // host writes to the parameter store
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sense_conductance_reg       <= ZERO_BYTE;
      full_voltage_threshold_reg  <= ZERO_BYTE;
      full_current_threshold_reg  <= ZERO_BYTE;
      empty_voltage_threshold_reg <= ZERO_BYTE;
      empty_current_threshold_reg <= ZERO_BYTE;
      aging_rated_charge_reg      <= '0;
      full40_reg                  <= '0;
      ae40_reg                    <= ZERO_BYTE;
      for (int i = 0; i < 3; i++) begin
        bp_reg[i] <= BP_TOP_TEMP;
      end
      for (int i = 0; i < 12; i++) begin
        slope_reg[i] <= ZERO_BYTE;
      end
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_SENSE_COND: sense_conductance_reg       <= reg_wdata;
        ADDR_FULL_CELL_STACK_POTENTIAL:  full_voltage_threshold_reg  <= reg_wdata;
        ADDR_FULL_CURR:  full_current_threshold_reg  <= reg_wdata;
        ADDR_EMPTY_CELL_STACK_POTENTIAL: empty_voltage_threshold_reg <= reg_wdata;
        ADDR_EMPTY_CURR: empty_current_threshold_reg <= reg_wdata;
        ADDR_AGING_HI:   aging_rated_charge_reg[15:8] <= reg_wdata;
        ADDR_AGING_LO:   aging_rated_charge_reg[7:0]  <= reg_wdata;
        ADDR_FULL40_HI:  full40_reg[15:8] <= reg_wdata;
        ADDR_FULL40_LO:  full40_reg[7:0]  <= reg_wdata;
        ADDR_AE40:       ae40_reg <= reg_wdata;
        ADDR_BP_LOW:     bp_reg[0] <= reg_wdata;
        ADDR_BP_MID:     bp_reg[1] <= reg_wdata;
        ADDR_BP_HIGH:    bp_reg[2] <= reg_wdata;
        default: begin
          // slope block: twelve consecutive bytes
          if (reg_addr >= ADDR_SLOPE_BASE &&
              reg_addr < ADDR_SLOPE_BASE + 8'h0C) begin
            slope_reg[4'(reg_addr - ADDR_SLOPE_BASE)] <= reg_wdata;
          end
        end
      endcase
    end
  end

  // age scalar: recall, host write, learn and aging
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      age_scalar_reg <= AGE_UNAGED;
    end else if (nv_recall) begin
      age_scalar_reg <= nv_age_value;
    end else if (full_event && learn_cycle_flag) begin
      age_scalar_reg <= age_learned_sat;
    end else if (aging_hit) begin
      // saturate rather than wrap
      if (age_scalar_reg > AGE_MIN) begin
        age_scalar_reg <= age_scalar_reg - 8'h01;
      end
    end else if (reg_wr && reg_addr == ADDR_AGE_SCALAR) begin
      age_scalar_reg <= reg_wdata;
    end
  end

  // periodic save of the age scalar
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      save_div_reg <= '0;
      nv_save_req  <= 1'b0;
      nv_save_data <= ZERO_BYTE;
    end else begin
      nv_save_req <= 1'b0;
      if (nv_save_tick) begin
        save_div_reg <= save_div_reg + 4'h1;
        if (save_div_reg == 4'hF) begin
          nv_save_req  <= 1'b1;
          nv_save_data <= age_scalar_reg;
        end
      end
    end
  end

  // flags; set wins over clear, except that a full event clears the learn flag over an empty set
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      full_charge_flag <= 1'b0;
      empty_point_flag <= 1'b0;
      learn_cycle_flag <= 1'b0;
    end else begin
      if (full_event) begin
        full_charge_flag <= 1'b1;
        learn_cycle_flag <= 1'b0;
      end else if (empty_event) begin
        learn_cycle_flag <= 1'b1;
      end else if (meas_update && sense_current < 16'sh0000) begin
        learn_cycle_flag <= learn_cycle_flag && v_below_ae;
      end
      if (meas_update && v_below_ae) begin
        empty_point_flag <= 1'b1;
      end else if (meas_update && coulomb_count > ae_model) begin
        empty_point_flag <= 1'b0;
      end
      // a full event in the same cycle outranks the empty clear
      if (meas_update && v_below_ae && !full_event) begin
        full_charge_flag <= 1'b0;
      end
    end
  end

  // coulomb count housekeeping
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      coulomb_count  <= '0;
      empty_mark_reg <= '0;
    end else if (full_event) begin
      // age-scaled full value, after learn update
      coulomb_count <= (learn_cycle_flag) ?
        16'((24'(full_model) * 24'(age_learned_sat)) >> 7) :
        full_scaled[22:7];
    end else if (empty_event) begin
      coulomb_count  <= ae_model;
      empty_mark_reg <= ae_model;
    end else if (meas_update && v_below_ae && !learn_cycle_flag &&
                 coulomb_count > ae_model) begin
      coulomb_count <= ae_model;
    end else if (reg_wr && reg_addr == ADDR_COUNT_HI) begin
      coulomb_count[15:8] <= reg_wdata;
    end else if (reg_wr && reg_addr == ADDR_COUNT_LO) begin
      coulomb_count[7:0] <= reg_wdata;
    end
  end

  // read path
  always_comb begin
    reg_rdata = ZERO_BYTE;
    unique case (reg_addr)
      ADDR_SENSE_COND: reg_rdata = sense_conductance_reg;
      ADDR_FULL_CELL_STACK_POTENTIAL:  reg_rdata = full_voltage_threshold_reg;
      ADDR_FULL_CURR:  reg_rdata = full_current_threshold_reg;
      ADDR_EMPTY_CELL_STACK_POTENTIAL: reg_rdata = empty_voltage_threshold_reg;
      ADDR_EMPTY_CURR: reg_rdata = empty_current_threshold_reg;
      ADDR_AGING_HI:   reg_rdata = aging_rated_charge_reg[15:8];
      ADDR_AGING_LO:   reg_rdata = aging_rated_charge_reg[7:0];
      ADDR_AGE_SCALAR: reg_rdata = age_scalar_reg;
      ADDR_BP_LOW:     reg_rdata = bp_reg[0];
      ADDR_BP_MID:     reg_rdata = bp_reg[1];
      ADDR_BP_HIGH:    reg_rdata = bp_reg[2];
      ADDR_COUNT_HI:   reg_rdata = coulomb_count[15:8];
      ADDR_COUNT_LO:   reg_rdata = coulomb_count[7:0];
      ADDR_STATUS: begin
        reg_rdata[BIT_FULL]  = full_charge_flag;
        reg_rdata[BIT_EMPTY] = empty_point_flag;
        reg_rdata[BIT_LEARN] = learn_cycle_flag;
      end
      default: reg_rdata = ZERO_BYTE;
    endcase
  end

  // checks, all on core_clk with the reset as disable
  full_sets_a: assert property (full_event |=>
    full_charge_flag && !learn_cycle_flag)
    else $error("full event did not set flag");
  empty_load_a: assert property ((empty_event && !full_event) |=>
    coulomb_count == $past(ae_model))
    else $error("empty point did not load count");
  age_floor_a: assert property (!$past(reg_wr) &&
    !$past(nv_recall) && $past(age_scalar_reg) >= AGE_MIN |->
    age_scalar_reg >= AGE_MIN) else $error("age scalar wrapped");
  learn_set_a: assert property ((empty_event && !full_event) |=>
    learn_cycle_flag)
    else $error("learn flag not set");
  save_req_a: assert property ((nv_save_tick && &save_div_reg) |=>
    nv_save_req && nv_save_data == $past(age_scalar_reg))
    else $error("periodic save missed");
  age_step_a: assert property (aging_hit && !nv_recall &&
    !(full_event && learn_cycle_flag) && age_scalar_reg > AGE_MIN |=>
    age_scalar_reg == $past(age_scalar_reg) - 8'h01)
    else $error("aging did not step the age scalar");

endmodule : battery_capacity_estimator
`default_nettype wire

// ==== tb/host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // clock
  input  wire logic       core_clk,
  // parameter store port
  output logic            reg_wr,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  // nonvolatile side
  output logic            nv_recall,
  output logic      [7:0] nv_age_value,
  output logic            nv_save_tick
);
  localparam time DRV = 10ns; // drive delay after the rising edge

  // idle values at time zero
  initial begin
    reg_wr       = 1'b0;
    reg_addr     = 8'h00;
    reg_wdata    = 8'h00;
    nv_recall    = 1'b0;
    nv_age_value = 8'h00;
    nv_save_tick = 1'b0;
  end

  // one edge, then step off it so the design sees settled inputs
  task automatic tick();
    @(posedge core_clk);
    #DRV;
  endtask : tick

  // single byte write; data garbled once the strobe drops
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    tick();
    reg_wr    = 1'b0;
    reg_wdata = ~d; // no stale value left on the bus
    tick();
  endtask : wr

  // combinational read, sampled within the same cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    #1;
    d = reg_rdata;
    tick();
  endtask : rd

  // power-up recall of the saved age value
  task automatic recall(input logic [7:0] v);
    nv_recall    = 1'b1;
    nv_age_value = v;
    tick();
    nv_recall    = 1'b0;
    nv_age_value = ~v; // stored copy no longer presented
    tick();
  endtask : recall

  // periodic save ticks, two cycles apart
  task automatic save_ticks(input int n);
    for (int k = 0; k < n; k++) begin
      nv_save_tick = 1'b1;
      tick();
      nv_save_tick = 1'b0;
      tick();
    end
  endtask : save_ticks
endmodule : host_model
`default_nettype wire

// ==== tb/battery_capacity_estimator_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module battery_capacity_estimator_tb;
  import capacity_pkg::*;
  logic core_clk = 1'b0, nrst = 1'b0;    // clock and reset
  logic reg_wr, nv_recall, nv_save_tick; // host strobes
  logic [7:0] reg_addr, reg_wdata, reg_rdata, nv_age_value, nv_save_data;
  logic nv_save_req, meas_update = 1'b0, avg_update = 1'b0;
  logic [7:0] cell_stack_potential = 8'h00;
  logic signed [15:0] sense_current = 16'sh0000;
  logic signed [15:0] averaged_current = 16'sh0000;
  logic signed [7:0]  temperature = 8'sh28; // held at the top breakpoint
  logic [15:0] count_step = 16'h0001, coulomb_count;
  logic full_charge_flag, empty_point_flag, learn_cycle_flag;
  int n_fail = 0, total_checks = 0, saves = 0; // counters
  logic [7:0] rv, save_seen;                   // scratch read data

  always #50 core_clk = ~core_clk; // 10 MHz

  // count save pulses and keep the data seen with them
  always @(posedge core_clk) begin
    if (nv_save_req === 1'b1) begin
      saves <= saves + 1;
      save_seen <= nv_save_data;
    end
  end

  host_model host (.core_clk(core_clk), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .nv_recall(nv_recall), .nv_age_value(nv_age_value),
    .nv_save_tick(nv_save_tick));

  battery_capacity_estimator DUT (.core_clk(core_clk), .nrst(nrst),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .nv_recall(nv_recall),
    .nv_age_value(nv_age_value), .nv_save_tick(nv_save_tick),
    .nv_save_req(nv_save_req), .nv_save_data(nv_save_data),
    .meas_update(meas_update), .cell_stack_potential(cell_stack_potential),
    .sense_current(sense_current), .avg_update(avg_update),
    .averaged_current(averaged_current), .temperature(temperature),
    .count_step(count_step), .coulomb_count(coulomb_count),
    .full_charge_flag(full_charge_flag), .empty_point_flag(empty_point_flag),
    .learn_cycle_flag(learn_cycle_flag));

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // compare a byte value
  task automatic check_val(input string nm, input logic [7:0] e,
                           input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : check_val

  // compare a single flag
  task automatic check_flag(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : check_flag

  // one measurement update, then a quiet cycle
  task automatic meas(input logic [7:0] v, input logic signed [15:0] i);
    meas_update = 1'b1;
    cell_stack_potential = v;
    sense_current = i;
    host.tick();
    meas_update = 1'b0;
    host.tick();
  endtask : meas

  // one averaged-current update, then a quiet cycle
  task automatic avg(input logic signed [15:0] a);
    avg_update = 1'b1;
    averaged_current = a;
    host.tick();
    avg_update = 1'b0;
    host.tick();
  endtask : avg

  // bounded wait on a flag; a run-out counts and ends the run
  task automatic wait_flag(ref logic f, input string nm);
    int k;
    for (k = 0; k < 20 && f !== 1'b1; k++) host.tick();
    if (k == 20) begin
      n_fail++;
      $display("[ERR] %s expected 1 seen timeout", nm);
      summarize();
    end
  endtask : wait_flag

  // reset values and an unmapped read
  task automatic t_reset();
    host.rd(ADDR_AGE_SCALAR, rv); check_val("age", 8'h80, rv);
    for (int a = 0; a < 3; a++) begin
      host.rd(ADDR_BP_LOW + a, rv);
      check_val("breakpoint", 8'h28, rv);
    end
    host.rd(8'h20, rv); check_val("unmapped", 8'h00, rv);
    check_flag("full", 1'b0, full_charge_flag);
    $display("test reset done");
  endtask : t_reset

  // parameter bytes written and read back; unmapped write ignored
  task automatic t_params();
    logic [7:0] adr [7];
    adr = '{ADDR_SENSE_COND, ADDR_FULL_CELL_STACK_POTENTIAL, ADDR_FULL_CURR,
            ADDR_EMPTY_CELL_STACK_POTENTIAL, ADDR_EMPTY_CURR, ADDR_AGING_HI, ADDR_AGING_LO};
    for (int k = 0; k < 7; k++) host.wr(adr[k], 8'hA5 ^ k[7:0]);
    host.wr(8'h20, 8'h5A);
    for (int k = 0; k < 7; k++) begin
      host.rd(adr[k], rv);
      check_val("param", 8'hA5 ^ k[7:0], rv);
    end
    host.wr(ADDR_BP_LOW, 8'hF4); host.rd(ADDR_BP_LOW, rv);
    check_val("bp_low", 8'hF4, rv);
    host.rd(8'h20, rv); check_val("unmapped", 8'h00, rv);
    $display("test params done");
  endtask : t_params

  // recall, then periodic save every sixteenth tick
  task automatic t_nv();
    host.recall(8'h7A);
    host.rd(ADDR_AGE_SCALAR, rv); check_val("age", 8'h7A, rv);
    host.save_ticks(15);
    check_val("saves", 8'h00, saves[7:0]);
    host.save_ticks(1);
    host.tick();
    check_val("saves", 8'h01, saves[7:0]);
    check_val("save_data", 8'h7A, save_seen);
    $display("test nv done");
  endtask : t_nv

  // aging: 32 unit steps drop the scalar once, then saturate
  task automatic t_aging();
    host.wr(ADDR_FULL_CELL_STACK_POTENTIAL, 8'h00); host.wr(ADDR_EMPTY_CELL_STACK_POTENTIAL, 8'h00);
    host.wr(ADDR_AGING_HI, 8'h00); host.wr(ADDR_AGING_LO, 8'h01);
    for (int k = 0; k < 31; k++) meas(8'h90, -16'sh0010);
    host.rd(ADDR_AGE_SCALAR, rv); check_val("age", 8'h7A, rv);
    meas(8'h90, -16'sh0010);
    host.rd(ADDR_AGE_SCALAR, rv); check_val("age", 8'h79, rv);
    host.wr(ADDR_AGE_SCALAR, AGE_MIN);
    for (int k = 0; k < 32; k++) meas(8'h90, -16'sh0010);
    host.rd(ADDR_AGE_SCALAR, rv); check_val("age", AGE_MIN, rv);
    $display("test aging done");
  endtask : t_aging

  // empty point: voltage falls under heavy discharge
  task automatic t_empty();
    host.wr(ADDR_EMPTY_CELL_STACK_POTENTIAL, 8'h80); host.wr(ADDR_EMPTY_CURR, 8'h10);
    host.wr(ADDR_COUNT_HI, 8'h12); host.wr(ADDR_COUNT_LO, 8'h34);
    meas(8'hA0, -16'sh4000);
    meas(8'hA0, -16'sh4000);
    check_flag("learn", 1'b0, learn_cycle_flag);
    meas(8'h70, -16'sh4000);
    wait_flag(learn_cycle_flag, "learn");
    wait_flag(empty_point_flag, "empty");
    host.rd(ADDR_STATUS, rv);
    check_flag("status_learn", 1'b1, rv[BIT_LEARN]);
    host.rd(ADDR_COUNT_HI, rv); check_val("count_hi", 8'h00, rv);
    check_val("count_lo", 8'h00, coulomb_count[7:0]);
    $display("test empty done");
  endtask : t_empty

  // full: voltage high across two small positive averages
  task automatic t_full();
    host.wr(ADDR_FULL_CELL_STACK_POTENTIAL, 8'h80); host.wr(ADDR_FULL_CURR, 8'hFF);
    host.wr(ADDR_FULL40_HI, 8'h01); host.wr(ADDR_FULL40_LO, 8'h00);
    host.wr(ADDR_AGE_SCALAR, 8'h70); // learn must replace this value
    meas(8'hC0, 16'sh0010);
    avg(16'sh0001);
    meas(8'hC0, 16'sh0010);
    avg(16'sh0001);
    wait_flag(full_charge_flag, "full");
    check_flag("learn", 1'b0, learn_cycle_flag);
    host.rd(ADDR_STATUS, rv);
    check_flag("status_full", 1'b1, rv[BIT_FULL]);
    // no charge since empty: learned age floors at the minimum code
    host.rd(ADDR_AGE_SCALAR, rv); check_val("age", AGE_MIN, rv);
    // full 0100h scaled by the new age 3Fh/80h gives 7Eh
    check_val("count_lo", 8'h7E, coulomb_count[7:0]);
    check_val("count_hi", 8'h00, coulomb_count[15:8]);
    $display("test full done");
  endtask : t_full

  // below the empty voltage with no learn cycle: count clamps down
  task automatic t_clamp();
    meas(8'h70, 16'sh0010);
    check_flag("learn", 1'b0, learn_cycle_flag);
    check_val("count_lo", 8'h00, coulomb_count[7:0]);
    $display("test clamp done");
  endtask : t_clamp

  // main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    #10 nrst = 1'b1;
    host.tick();
    t_reset();
    t_params();
    t_nv();
    t_aging();
    t_empty();
    t_full();
    t_clamp();
    summarize();
  end
endmodule : battery_capacity_estimator_tb
`default_nettype wire
